// [hw/rtmr_top.sv]
// Reference trim and margin-high registers with reference computation
`timescale 1ns/1ps
`default_nettype none

// Function
// - Trim adds constant offset to reference code
// - Store-all copies trim to nonvolatile storage
// - Loop slave discards trim and margin writes
// - Loop slave access: NACK, invalid command, alert
// - Output mode fixed linear, exponent minus nine
// - Reference sums scaled command, trim, margins
// - Trim accepts signed codes -64 to +63
// - Out-of-range write clamps, alerts, flags status
// - Reference bounded by scaled output limits
// - Ramp rate chosen by operating state
// - Trim: seven writable bits, sign extended
// - Margin-high accepts codes 0 to 31
// - Margin-high: five writable bits, rest zero
// - Margin-high restores 0009h or 000Fh by option
// - Margin-high step only in margin-high operation
module rtmr_top (
  // Core clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Link clock and decoded command frames
  input wire logic link_clk_in,
  input wire logic frame_valid_in,
  input wire logic frame_write_in,
  input wire logic [7:0] frame_cmd_in,
  input wire logic [15:0] frame_wdata_in,
  // Answers on the link clock
  output logic busy_out,
  output logic resp_valid_out,
  output logic resp_ack_out,
  output logic [15:0] resp_rdata_out,
  // Configuration from the rest of the device
  input wire logic loop_slave_in,
  input wire logic margin_high_restore_select_in,
  input wire logic [7:0] operation_in,
  input wire logic [15:0] vout_command_in,
  input wire logic [15:0] vout_scale_loop_in,
  input wire logic [15:0] vout_max_in,
  input wire logic [15:0] vout_min_in,
  input wire logic [15:0] margin_low_step_in,
  // Ramp rate sources and operating state
  input wire logic [1:0] ramp_state_in,
  input wire logic [15:0] ton_rise_in,
  input wire logic [15:0] transition_rate_in,
  input wire logic [15:0] toff_fall_in,
  // Nonvolatile storage commands
  input wire logic store_all_in,
  input wire logic restore_all_in,
  input wire logic [15:0] nvm_trim_in,
  output logic nvm_trim_we_out,
  output logic [15:0] nvm_trim_data_out,
  // Status and alert
  input wire logic clear_faults_in,
  output logic invalid_command_fault_out,
  output logic invalid_data_out,
  output logic status_cml_out,
  output logic alert_out,
  // Reference and ramp outputs
  output logic [7:0] vout_mode_out,
  output logic [15:0] error_amp_reference_out,
  output logic [15:0] ramp_rate_out
);

  typedef struct packed {
    logic [2:0] req_sync;
    logic ack_tgl;
    logic ack;
    logic [15:0] rdata;
    logic [6:0] trim;
    logic [4:0] mhi;
    logic init;
    logic invalid_command_fault;
    logic inv_data;
    logic cml;
    logic alert;
    logic nvm_we;
    logic [15:0] nvm_data;
    logic [15:0] ref_code;
    logic [15:0] ramp;
    logic [7:0] mode;
  } rtmr_core_state_t;

  rtmr_core_state_t state;
  rtmr_core_state_t next_state;
  rtmr_link_if link_bus ();

  // Crossing and command decode
  logic req_seen;
  logic cmd_trim;
  logic cmd_mhi;
  logic cmd_refused;

  // Reference arithmetic
  logic [31:0] cmd_prod;
  logic [31:0] max_prod;
  logic [31:0] min_prod;
  logic signed [18:0] ref_sum;
  logic signed [18:0] ref_hi;
  logic signed [18:0] ref_lo;
  logic signed [18:0] ref_clamped;

  // Write clamps and read-back words
  logic signed [15:0] wdata_s;
  logic [6:0] trim_wr;
  logic trim_bad;
  logic [4:0] mhi_wr;
  logic mhi_bad;
  logic [15:0] trim_rd;
  logic [15:0] mhi_rd;

  // Restore and reload values
  logic [4:0] mhi_restore;
  logic [15:0] nvm_trim_s;
  logic [6:0] nvm_trim_fit;

  // Link-clock front end
  rtmr_link u_link (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .frame_valid_in(frame_valid_in),
    .frame_write_in(frame_write_in),
    .frame_cmd_in(frame_cmd_in),
    .frame_wdata_in(frame_wdata_in),
    .busy_out(busy_out),
    .resp_valid_out(resp_valid_out),
    .resp_ack_out(resp_ack_out),
    .resp_rdata_out(resp_rdata_out),
    .bus(link_bus.link)
  );

  // A new request shows as a change of the synchronised toggle; the
  // link holds command and data until it sees the answer, so the
  // core may read them without a second synchroniser
  assign req_seen = state.req_sync[2] ^ state.req_sync[1];

  // Command decode; a loop slave refuses both registers
  assign cmd_trim = link_bus.cmd == rtmr_pkg::CMD_TRIM;
  assign cmd_mhi = link_bus.cmd == rtmr_pkg::CMD_MARGIN_HIGH;
  assign cmd_refused = loop_slave_in || !(cmd_trim || cmd_mhi);

  assign cmd_prod = vout_command_in * vout_scale_loop_in;
  assign max_prod = vout_max_in * vout_scale_loop_in;
  assign min_prod = vout_min_in * vout_scale_loop_in;

  // drop the fraction bits; a scale near 2.0 needs bit 31
  assign ref_hi = $signed({2'b00, max_prod[31:15]});
  assign ref_lo = $signed({2'b00, min_prod[31:15]});

  // trim and margin steps added to scaled command
  always_comb begin
    ref_sum = $signed({2'b00, cmd_prod[31:15]});
    ref_sum = ref_sum + 19'($signed(state.trim));
    if (operation_in[rtmr_pkg::OP_MARGIN_HIGH_BIT]) begin
      ref_sum = ref_sum + $signed({14'h0000, state.mhi});
    end
    if (operation_in[rtmr_pkg::OP_MARGIN_LOW_BIT]) begin
      ref_sum = ref_sum + 19'($signed(margin_low_step_in));
    end
  end

  // bound by limits, never below zero
  always_comb begin
    ref_clamped = ref_sum;
    if (ref_clamped > ref_hi) begin
      ref_clamped = ref_hi;
    end
    if (ref_clamped < ref_lo) begin
      ref_clamped = ref_lo;
    end
    if (ref_clamped < 19'sh00000) begin
      ref_clamped = 19'sh00000;
    end
    // Output code is 16 bits: saturate instead of wrapping
    if (ref_clamped > 19'sh0FFFF) begin
      ref_clamped = 19'sh0FFFF;
    end
  end

  assign wdata_s = $signed(link_bus.wdata);
  always_comb begin
    trim_wr = wdata_s[6:0];
    trim_bad = 1'b0;
    if (wdata_s > rtmr_pkg::TRIM_MAX) begin
      trim_wr = rtmr_pkg::TRIM_MAX[6:0];
      trim_bad = 1'b1;
    end else if (wdata_s < rtmr_pkg::TRIM_MIN) begin
      trim_wr = rtmr_pkg::TRIM_MIN[6:0];
      trim_bad = 1'b1;
    end
  end

  always_comb begin
    mhi_wr = wdata_s[4:0];
    mhi_bad = 1'b0;
    if (wdata_s < 16'sh0000) begin
      mhi_wr = 5'h00;
      mhi_bad = 1'b1;
    end else if (wdata_s > rtmr_pkg::MHI_MAX) begin
      mhi_wr = rtmr_pkg::MHI_MAX[4:0];
      mhi_bad = 1'b1;
    end
  end

  assign trim_rd = {{9{state.trim[6]}}, state.trim};
  assign mhi_rd = {11'h000, state.mhi};

  // restore value picked by the option bit
  assign mhi_restore = margin_high_restore_select_in ?
    rtmr_pkg::MHI_RESTORE_1 : rtmr_pkg::MHI_RESTORE_0;

  // Stored trim limited to the seven-bit field on reload
  assign nvm_trim_s = nvm_trim_in;
  always_comb begin
    nvm_trim_fit = nvm_trim_s[6:0];
    if ($signed(nvm_trim_s) > rtmr_pkg::TRIM_MAX) begin
      nvm_trim_fit = rtmr_pkg::TRIM_MAX[6:0];
    end else if ($signed(nvm_trim_s) < rtmr_pkg::TRIM_MIN) begin
      nvm_trim_fit = rtmr_pkg::TRIM_MIN[6:0];
    end
  end

  // Next-state logic of the core
  always_comb begin
    next_state = state;
    next_state.req_sync = {state.req_sync[1:0], link_bus.req_tgl};
    next_state.nvm_we = 1'b0;
    next_state.ref_code = ref_clamped[15:0];
    case (rtmr_pkg::rtmr_ramp_state_t'(ramp_state_in))
      rtmr_pkg::RTMR_SOFT_START: next_state.ramp = ton_rise_in;
      rtmr_pkg::RTMR_STEADY: next_state.ramp = transition_rate_in;
      rtmr_pkg::RTMR_TOFF_DELAY: next_state.ramp = transition_rate_in;
      rtmr_pkg::RTMR_SOFT_STOP: next_state.ramp = toff_fall_in;
      default: next_state.ramp = transition_rate_in;
    endcase
    // Software clear of sticky status; events below win
    if (clear_faults_in) begin
      next_state.invalid_command_fault = 1'b0;
      next_state.inv_data = 1'b0;
      next_state.cml = 1'b0;
      next_state.alert = 1'b0;
    end
    // restore value on power-up and on reload
    if (state.init || restore_all_in) begin
      next_state.init = 1'b0;
      next_state.mhi = mhi_restore;
    end
    // Reload trim from storage, already limited to its range
    if (restore_all_in) begin
      next_state.trim = nvm_trim_fit;
    end
    // copy trim to storage on store-all
    if (store_all_in) begin
      next_state.nvm_we = 1'b1;
      next_state.nvm_data = trim_rd;
    end
    // Command handling, one per synchronised request
    if (req_seen) begin
      next_state.ack_tgl = ~state.ack_tgl;
      next_state.ack = 1'b0;
      next_state.rdata = 16'h0000;
      if (cmd_refused) begin
        next_state.invalid_command_fault = 1'b1;
        next_state.cml = 1'b1;
        next_state.alert = 1'b1;
      end else if (cmd_trim) begin
        next_state.ack = 1'b1;
        if (link_bus.write) begin
          next_state.trim = trim_wr;
          if (trim_bad) begin
            next_state.inv_data = 1'b1;
            next_state.cml = 1'b1;
            next_state.alert = 1'b1;
          end
        end else begin
          next_state.rdata = trim_rd;
        end
      end else begin
        next_state.ack = 1'b1;
        if (link_bus.write) begin
          next_state.mhi = mhi_wr;
          if (mhi_bad) begin
            next_state.inv_data = 1'b1;
            next_state.cml = 1'b1;
            next_state.alert = 1'b1;
          end
        end else begin
          next_state.rdata = mhi_rd;
        end
      end
    end
    // Synchronous reset to defined values
    if (rst_in) begin
      next_state = '0;
      next_state.trim = rtmr_pkg::TRIM_RESET;
      next_state.init = 1'b1;
    end
    // mode is fixed, so it holds its value through reset as well
    next_state.mode = rtmr_pkg::VOUT_MODE_FIXED;
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    state <= next_state;
  end

  // Answer back to the link side
  assign link_bus.ack_tgl = state.ack_tgl;
  assign link_bus.ack = state.ack;
  assign link_bus.rdata = state.rdata;

  // Storage port, straight from flops
  assign nvm_trim_we_out = state.nvm_we;
  assign nvm_trim_data_out = state.nvm_data;

  // Sticky status, straight from flops
  assign invalid_command_fault_out = state.invalid_command_fault;
  assign invalid_data_out = state.inv_data;
  assign status_cml_out = state.cml;
  assign alert_out = state.alert;

  // fixed output mode, from its own flop
  assign vout_mode_out = state.mode;

  // Reference and ramp rate, straight from flops
  assign error_amp_reference_out = state.ref_code;
  assign ramp_rate_out = state.ramp;

endmodule : rtmr_top
`default_nettype wire

// [hw/rtmr_pkg.sv]
// Package: constants and types of the reference trim and margin registers
package rtmr_pkg;

  // Command codes on the management link
  localparam logic [7:0] CMD_TRIM = 8'hD4;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD5;

  // Trim field: low six bits plus sign, two's complement limits
  localparam int TRIM_W = 7;
  localparam logic signed [15:0] TRIM_MIN = 16'shFFC0;
  localparam logic signed [15:0] TRIM_MAX = 16'sh003F;
  localparam logic [6:0] TRIM_RESET = 7'h00;

  // Margin-high field: five writable bits, positive only
  localparam int MHI_W = 5;
  localparam logic signed [15:0] MHI_MAX = 16'sh001F;
  localparam logic [4:0] MHI_RESTORE_0 = 5'h09;
  localparam logic [4:0] MHI_RESTORE_1 = 5'h0F;

  // Operation bits that enable the margin steps
  localparam int OP_MARGIN_HIGH_BIT = 5;
  localparam int OP_MARGIN_LOW_BIT = 4;

  // Output mode: linear, exponent minus nine, fixed
  localparam logic [7:0] VOUT_MODE_FIXED = 8'h17;
  // One reference code step in millivolts times one thousand
  localparam int REF_LSB_UV_X1000 = 1953;

  // Loop scale is an unsigned fraction with this many fraction bits
  localparam int SCALE_FRAC = 15;

  // Operating states that choose the reference ramp rate
  typedef enum logic [1:0] {
    RTMR_SOFT_START = 2'h0,
    RTMR_STEADY = 2'h1,
    RTMR_TOFF_DELAY = 2'h3,
    RTMR_SOFT_STOP = 2'h2
  } rtmr_ramp_state_t;

endpackage : rtmr_pkg

// [hw/rtmr_link_if.sv]
// Interface: request and answer between link-clock and core-clock logic
`timescale 1ns/1ps
`default_nettype none
interface rtmr_link_if;
  // Request side, driven on the link clock, held while pending
  logic req_tgl;
  logic write;
  logic [7:0] cmd;
  logic [15:0] wdata;
  // Answer side, driven on the core clock, held until next request
  logic ack_tgl;
  logic ack;
  logic [15:0] rdata;

  modport link (
    output req_tgl, write, cmd, wdata,
    input ack_tgl, ack, rdata
  );
  modport core (
    input req_tgl, write, cmd, wdata,
    output ack_tgl, ack, rdata
  );
endinterface : rtmr_link_if
`default_nettype wire

// [hw/rtmr_link.sv]
// Link-clock front end: takes decoded command frames, hands them across
`timescale 1ns/1ps
`default_nettype none
module rtmr_link (
  // Link clock and reset from the core domain
  input wire logic link_clk_in,
  input wire logic rst_in,
  // Decoded frames from the link
  input wire logic frame_valid_in,
  input wire logic frame_write_in,
  input wire logic [7:0] frame_cmd_in,
  input wire logic [15:0] frame_wdata_in,
  // Answer to the link
  output logic busy_out,
  output logic resp_valid_out,
  output logic resp_ack_out,
  output logic [15:0] resp_rdata_out,
  // Crossing to the core
  rtmr_link_if.link bus
);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] ack_sync;
    logic req_tgl;
    logic write;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic busy;
    logic resp_valid;
    logic resp_ack;
    logic [15:0] resp_rdata;
  } rtmr_link_state_t;

  rtmr_link_state_t state;
  rtmr_link_state_t next_state;

  // Frame capture, toggle request, wait for toggled answer
  always_comb begin
    next_state = state;
    next_state.rst_sync = {state.rst_sync[0], rst_in};
    next_state.ack_sync = {state.ack_sync[1:0], bus.ack_tgl};
    next_state.resp_valid = 1'b0;
    if (state.rst_sync[1]) begin
      next_state.req_tgl = 1'b0;
      next_state.write = 1'b0;
      next_state.cmd = 8'h00;
      next_state.wdata = 16'h0000;
      next_state.busy = 1'b0;
      next_state.resp_ack = 1'b0;
      next_state.resp_rdata = 16'h0000;
    end else if (!state.busy && frame_valid_in) begin
      next_state.write = frame_write_in;
      next_state.cmd = frame_cmd_in;
      next_state.wdata = frame_wdata_in;
      next_state.req_tgl = ~state.req_tgl;
      next_state.busy = 1'b1;
    end else if (state.busy && (state.ack_sync[2] != state.ack_sync[1])) begin
      next_state.busy = 1'b0;
      next_state.resp_valid = 1'b1;
      next_state.resp_ack = bus.ack;
      next_state.resp_rdata = bus.rdata;
    end
  end

  // State register
  always_ff @(posedge link_clk_in) begin
    state <= next_state;
  end

  // Outputs and crossing signals straight from flops
  assign busy_out = state.busy;
  assign resp_valid_out = state.resp_valid;
  assign resp_ack_out = state.resp_ack;
  assign resp_rdata_out = state.resp_rdata;
  assign bus.req_tgl = state.req_tgl;
  assign bus.write = state.write;
  assign bus.cmd = state.cmd;
  assign bus.wdata = state.wdata;

endmodule : rtmr_link
`default_nettype wire

// [dv/rtmr_checker.sv]
// Checker: port-level properties of the reference trim block
`timescale 1ns/1ps
`default_nettype none
module rtmr_checker (
  // Clocks and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  // Link side
  input wire logic frame_valid_in,
  input wire logic frame_write_in,
  input wire logic [7:0] frame_cmd_in,
  input wire logic busy_out,
  input wire logic resp_valid_out,
  input wire logic resp_ack_out,
  input wire logic [15:0] resp_rdata_out,
  // Core side
  input wire logic [1:0] ramp_state_in,
  input wire logic [15:0] ton_rise_in,
  input wire logic [15:0] transition_rate_in,
  input wire logic [15:0] toff_fall_in,
  input wire logic store_all_in,
  input wire logic clear_faults_in,
  input wire logic nvm_trim_we_out,
  input wire logic invalid_command_fault_out,
  input wire logic invalid_data_out,
  input wire logic status_cml_out,
  input wire logic alert_out,
  input wire logic [7:0] vout_mode_out,
  input wire logic [15:0] ramp_rate_out
);
  logic [15:0] rate_q;
  logic [7:0] cmd_q;
  logic wr_q;
  // Rate that the state seen last cycle selects
  always_ff @(posedge core_clk_in) begin
    case (ramp_state_in)
      2'h0: rate_q <= ton_rise_in;
      2'h2: rate_q <= toff_fall_in;
      default: rate_q <= transition_rate_in;
    endcase
  end
  // Command of the frame in flight
  always_ff @(posedge link_clk_in) begin
    if (frame_valid_in && !busy_out) begin
      cmd_q <= frame_cmd_in;
      wr_q <= frame_write_in;
    end
  end
  // Core-domain properties
  chk_mode_fixed: assert property (@(posedge core_clk_in)
    disable iff (rst_in) vout_mode_out == 8'h17)
    else $error("output mode not fixed");
  chk_rate_select: assert property (@(posedge core_clk_in)
    disable iff (rst_in) !$past(rst_in) |-> ramp_rate_out == rate_q)
    else $error("ramp rate not from state");
  chk_store_pulse: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    !$past(rst_in) |-> nvm_trim_we_out == $past(store_all_in))
    else $error("store pulse wrong");
  chk_alert_hold: assert property (@(posedge core_clk_in)
    disable iff (rst_in) $fell(alert_out) |-> $past(clear_faults_in))
    else $error("alert dropped without clear");
  chk_fault_flags: assert property (@(posedge core_clk_in)
    disable iff (rst_in)
    invalid_data_out || invalid_command_fault_out
    |-> alert_out && status_cml_out)
    else $error("fault without alert");
  // Link-domain properties
  chk_nack_logged: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    resp_valid_out && !resp_ack_out |-> $past(invalid_command_fault_out))
    else $error("nack without fault");
  chk_mhi_bits: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    resp_valid_out && resp_ack_out && !wr_q && cmd_q == 8'hD5
    |-> resp_rdata_out[15:5] == 11'h000)
    else $error("margin read high bits set");
  chk_trim_sext: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    resp_valid_out && resp_ack_out && !wr_q && cmd_q == 8'hD4
    |-> resp_rdata_out[15:6] == 10'h000
    || resp_rdata_out[15:6] == 10'h3FF)
    else $error("trim read not sign extended");
  chk_answer_time: assert property (@(posedge link_clk_in)
    disable iff (rst_in)
    frame_valid_in && !busy_out |=> busy_out ##[3:4] resp_valid_out)
    else $error("answer late");
endmodule : rtmr_checker
bind rtmr_top rtmr_checker i_rtmr_checker (.core_clk_in, .rst_in,
  .link_clk_in, .frame_valid_in, .frame_write_in, .frame_cmd_in,
  .busy_out, .resp_valid_out, .resp_ack_out, .resp_rdata_out,
  .ramp_state_in, .ton_rise_in, .transition_rate_in, .toff_fall_in,
  .store_all_in, .clear_faults_in, .nvm_trim_we_out,
  .invalid_command_fault_out, .invalid_data_out, .status_cml_out,
  .alert_out, .vout_mode_out, .ramp_rate_out);
`default_nettype wire

// [dv/rtmr_host_model.sv]
// Host model: offers decoded command frames on the link clock
`timescale 1ns/1ps
`default_nettype none
module rtmr_host_model (
  // Link clock and answer
  input wire logic link_clk_in,
  input wire logic busy_in,
  input wire logic resp_valid_in,
  // Frame lines
  output logic frame_valid_out,
  output logic frame_write_out,
  output logic [7:0] frame_cmd_out,
  output logic [15:0] frame_wdata_out
);
  // Idle lines
  initial begin
    frame_valid_out = 1'b0;
    frame_write_out = 1'b0;
    frame_cmd_out = 8'h00;
    frame_wdata_out = 16'h0000;
  end
  // One frame: wait idle, offer one cycle, scramble lines, await answer
  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, input int gap, output logic ok);
    int n;
    ok = 1'b0;
    n = 0;
    repeat (gap) @(negedge link_clk_in);
    @(negedge link_clk_in);
    while (busy_in && n < 20) begin
      @(negedge link_clk_in);
      n++;
    end
    frame_valid_out = 1'b1;
    frame_write_out = w;
    frame_cmd_out = c;
    frame_wdata_out = d;
    @(negedge link_clk_in);
    // Released lines no longer show the frame
    frame_valid_out = 1'b0;
    frame_write_out = ~w;
    frame_cmd_out = ~c;
    frame_wdata_out = ~d;
    for (n = 0; n < 20 && !ok; n++) begin
      ok = resp_valid_in;
      if (!ok) @(negedge link_clk_in);
    end
  endtask : xfer
endmodule : rtmr_host_model
`default_nettype wire

// [dv/rtmr_top_tb_top.sv]
// Testbench: register access, clamps, reference and ramp selection
`timescale 1ns/1ps
`default_nettype none
module rtmr_top_tb_top;
  logic core_clk_in, rst_in, link_clk_in;
  logic frame_valid_in, frame_write_in, busy_out, resp_valid_out;
  logic [7:0] frame_cmd_in, operation_in, vout_mode_out;
  logic [15:0] frame_wdata_in, resp_rdata_out, nvm_trim_in;
  logic resp_ack_out, loop_slave_in, margin_high_restore_select_in;
  logic [15:0] vout_command_in, vout_scale_loop_in, vout_max_in;
  logic [15:0] vout_min_in, margin_low_step_in, ton_rise_in;
  logic [15:0] transition_rate_in, toff_fall_in, nvm_trim_data_out;
  logic [15:0] error_amp_reference_out, ramp_rate_out;
  logic [1:0] ramp_state_in;
  logic store_all_in, restore_all_in, nvm_trim_we_out, clear_faults_in;
  logic invalid_command_fault_out, invalid_data_out, status_cml_out;
  logic alert_out;
  int miscompares, cmp_count;
  logic [16:0] exp_q[$];
  logic [31:0] rng = 32'h0000BEAF;
  // Device and host
  rtmr_top i_rtmr_top (.core_clk_in, .rst_in, .link_clk_in,
    .frame_valid_in, .frame_write_in, .frame_cmd_in, .frame_wdata_in,
    .busy_out, .resp_valid_out, .resp_ack_out, .resp_rdata_out,
    .loop_slave_in, .margin_high_restore_select_in, .operation_in,
    .vout_command_in, .vout_scale_loop_in, .vout_max_in, .vout_min_in,
    .margin_low_step_in, .ramp_state_in, .ton_rise_in,
    .transition_rate_in, .toff_fall_in, .store_all_in, .restore_all_in,
    .nvm_trim_in, .nvm_trim_we_out, .nvm_trim_data_out, .clear_faults_in,
    .invalid_command_fault_out, .invalid_data_out, .status_cml_out,
    .alert_out, .vout_mode_out, .error_amp_reference_out, .ramp_rate_out);
  rtmr_host_model i_rtmr_host_model (.link_clk_in, .busy_in(busy_out),
    .resp_valid_in(resp_valid_out), .frame_valid_out(frame_valid_in),
    .frame_write_out(frame_write_in), .frame_cmd_out(frame_cmd_in),
    .frame_wdata_out(frame_wdata_in));
  // Clocks, unrelated in phase
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #3.7;
    forever #32 link_clk_in = ~link_clk_in;
  end
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // Note expected answer, run frame with a random host delay
  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic [16:0] e);
    logic ok;
    exp_q.push_back(e);
    i_rtmr_host_model.xfer(w, c, d, int'(xs() % 4), ok);
    if (!ok) begin
      miscompares++;
      print_verdict();
    end
  endtask : xfer
  task automatic pulse(ref logic s);
    @(negedge core_clk_in);
    s = 1'b1;
    @(negedge core_clk_in);
    s = 1'b0;
    @(negedge core_clk_in);
  endtask : pulse
  task automatic ref_chk(input logic [7:0] op, input logic [15:0] mx,
      input logic [15:0] e);
    @(negedge core_clk_in);
    operation_in = op;
    vout_max_in = mx;
    repeat (2) @(negedge core_clk_in);
    chk(error_amp_reference_out, e);
  endtask : ref_chk
  // Answer watcher: oldest note against each answer
  always @(negedge link_clk_in) begin
    if (resp_valid_out === 1'b1) chk({resp_ack_out, resp_rdata_out},
      exp_q.pop_front());
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] d;
    {rst_in, loop_slave_in, margin_high_restore_select_in} = 3'h4;
    {operation_in, vout_min_in, ramp_state_in} = '0;
    {vout_command_in, vout_scale_loop_in} = 32'h01008000;
    {vout_max_in, margin_low_step_in} = 32'hFFFFFFFE;
    {ton_rise_in, transition_rate_in} = 32'h11112222;
    {toff_fall_in, nvm_trim_in} = 32'h3333FF00;
    {store_all_in, restore_all_in, clear_faults_in} = 3'h0;
    repeat (10) @(negedge link_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge link_clk_in);
    xfer(1'b0, 8'hD4, 16'h0000, 17'h10000);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h10009);
    xfer(1'b0, 8'hD0, 16'h0000, 17'h00000);
    pulse(clear_faults_in);
    for (int i = 0; i < 5; i++) begin
      r = xs();
      d = {{10{r[6]}}, r[5:0]};
      xfer(1'b1, 8'hD4, d, 17'h10000);
      xfer(1'b0, 8'hD4, 16'h0000, {1'b1, d});
    end
    chk({invalid_data_out, alert_out}, 2'h0);
    xfer(1'b1, 8'hD4, 16'h0040, 17'h10000);
    xfer(1'b0, 8'hD4, 16'h0000, 17'h1003F);
    chk({invalid_data_out, status_cml_out, alert_out}, 3'h7);
    xfer(1'b1, 8'hD4, 16'hFF00, 17'h10000);
    xfer(1'b0, 8'hD4, 16'h0000, 17'h1FFC0);
    pulse(clear_faults_in);
    chk({invalid_data_out, status_cml_out, alert_out}, 3'h0);
    xfer(1'b1, 8'hD5, 16'h0020, 17'h10000);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h1001F);
    xfer(1'b1, 8'hD5, 16'hFFFF, 17'h10000);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h10000);
    xfer(1'b1, 8'hD5, 16'h0015, 17'h10000);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h10015);
    // Trim -64, command 100h, scale 1.0, margin-low -2
    ref_chk(8'h00, 16'hFFFF, 16'h00C0);
    ref_chk(8'h20, 16'hFFFF, 16'h00D5);
    ref_chk(8'h10, 16'hFFFF, 16'h00BE);
    ref_chk(8'h30, 16'hFFFF, 16'h00D3);
    ref_chk(8'h20, 16'h00C8, 16'h00C8);
    vout_min_in = 16'h00D0;
    ref_chk(8'h00, 16'hFFFF, 16'h00D0);
    chk(vout_mode_out, 8'h17);
    for (int s = 0; s < 4; s++) begin
      @(negedge core_clk_in);
      ramp_state_in = 2'(s);
      @(negedge core_clk_in);
      chk(ramp_rate_out, s == 0 ? 16'h1111 : s == 2 ? 16'h3333 :
        16'h2222);
    end
    // Store strobe: the write pulse stands for one cycle only
    @(negedge core_clk_in);
    store_all_in = 1'b1;
    @(negedge core_clk_in);
    store_all_in = 1'b0;
    chk({nvm_trim_we_out, nvm_trim_data_out}, 17'h1FFC0);
    @(negedge core_clk_in);
    chk(nvm_trim_we_out, 1'b0);
    @(negedge core_clk_in);
    {margin_high_restore_select_in, nvm_trim_in} = 17'h10005;
    pulse(restore_all_in);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h1000F);
    xfer(1'b0, 8'hD4, 16'h0000, 17'h10005);
    @(negedge core_clk_in);
    loop_slave_in = 1'b1;
    xfer(1'b1, 8'hD4, 16'h0001, 17'h00000);
    xfer(1'b1, 8'hD5, 16'h0003, 17'h00000);
    xfer(1'b0, 8'hD4, 16'h0000, 17'h00000);
    chk({invalid_command_fault_out, alert_out}, 2'h3);
    @(negedge core_clk_in);
    loop_slave_in = 1'b0;
    xfer(1'b0, 8'hD4, 16'h0000, 17'h10005);
    xfer(1'b0, 8'hD5, 16'h0000, 17'h1000F);
    repeat (2) @(negedge core_clk_in);
    print_verdict();
  end
endmodule : rtmr_top_tb_top
`default_nettype wire
